/* File: logic/analog_path_config_register.sv */
`timescale 1ns/1ps
`include "apc_consts.svh"

// Contract
// RULE1 - power-on and reset function reload the register from stored bits
// RULE2 - stored bits span eleven down to zero, factory value 440 hex
// RULE3 - host may read the register and load new values serially
// RULE4 - on host request the register is copied into the stored bits
// RULE5 - bits two to zero pick one of eight volume steps
// RULE6 - bit three routes the input to outputs while recording
// RULE7 - bit four with feed-through picks aux or mic plus aux recording
// RULE8 - bit five disables sound effect editing when set
// RULE9 - serial mode takes feed-through from bit six, pin otherwise
// RULE10 - feed-through off: no idle path, mic recording, storage playback
// RULE11 - feed-through on: idle feeds input, playback mixes aux with storage
// RULE12 - path comes from bits three, four and the feed-through source
// RULE13 - bit seven picks current output or aux output driver
// RULE14 - bit eight disables the speaker bridge outputs
// RULE15 - bit nine keeps the analog output powered off
// RULE16 - bit eleven makes ranged playback stop at message end
// RULE17 - track power, record, play and feed-through states from requests
// RULE18 - register holds until load or reset, paths follow it at once; code updates path outputs one cycle later
module analog_path_config_register
  import apc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              reset_func_req,
  input  wire logic [`APC_W-1:0] nonvolatile_config_bits,
  input  wire logic              cfg_load_strobe,
  input  wire logic [`APC_W-1:0] cfg_load_data,
  input  wire logic              cfg_read_strobe,
  output logic                   cfg_read_valid,
  output logic      [`APC_W-1:0] cfg_read_data,
  input  wire logic              cfg_commit_strobe,
  output logic                   nv_write_strobe,
  output logic      [`APC_W-1:0] nv_write_data,
  input  wire logic              serial_power_up_cmd,
  input  wire logic              power_down_cmd,
  input  wire logic              passthru_pin_n,
  input  wire logic              record_start,
  input  wire logic              play_start,
  input  wire logic              op_stop,
  output logic                   serial_mode,
  output fsm_t                   op_state,
  output logic      [`APC_W-1:0] analog_path_config,
  output logic      [2:0]        volume_step,
  output logic                   effect_edit_disable,
  output logic                   current_output,
  output logic                   aux_output,
  output logic                   speaker_bridge_disable,
  output logic                   output_power_off,
  output logic                   message_end_stop,
  output logic                   rec_mic,
  output logic                   rec_aux,
  output logic                   ft_mic,
  output logic                   ft_aux,
  output logic                   play_storage,
  output logic                   play_aux
);

  //////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [`APC_W-1:0] cfg;
    logic              cur_out;
    logic              load_pending;
    logic              serial_mode;
    fsm_t              op;
    logic              read_valid;
    logic [`APC_W-1:0] read_data;
    logic              nv_wr;
    logic [`APC_W-1:0] nv_data;
    path_sel_t         sel;
  } regs_t;

  localparam logic [`APC_W-1:0] FACTORY_CFG = `APC_FACTORY;

  // the stored bits are only sampled after reset is released
  localparam regs_t REGS_RESET = '{
    cfg:          `APC_FACTORY,
    cur_out:      !FACTORY_CFG[`APC_DRV_BIT],
    load_pending: 1'b1,
    serial_mode:  1'b0,
    op:           OP_POWER_DOWN,
    read_valid:   1'b0,
    read_data:    '0,
    nv_wr:        1'b0,
    nv_data:      '0,
    sel:          '0
  };

  regs_t r;
  regs_t next_r;
  logic  ft_on;
  fsm_t  rest_op;

  path_sel_if u_path ();

  //////////////////////////////////////////////////////////////////////////
  // path decode

  // pin is ignored once serial mode owns feed-through [RULE9] [RULE12]
  assign ft_on = r.serial_mode ? !r.cfg[`APC_SFT_BIT] : !passthru_pin_n;

  assign u_path.cfg   = r.cfg;
  assign u_path.ft_on = ft_on;
  assign u_path.op    = r.op;

  path_decode u_decode (
    .bus (u_path.decoder)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    next_r.load_pending = 1'b0;
    // reload from stored bits wins over a serial load [RULE1] [RULE2]
    if (r.load_pending || reset_func_req) begin
      next_r.cfg = nonvolatile_config_bits;
    end else if (cfg_load_strobe) begin
      next_r.cfg = cfg_load_data; // [RULE3] [RULE18]
    end
    // reads and commits see the value before a same-cycle load
    next_r.read_valid = cfg_read_strobe; // [RULE3]
    if (cfg_read_strobe) begin
      next_r.read_data = r.cfg;
    end
    next_r.nv_wr = cfg_commit_strobe; // [RULE4]
    if (cfg_commit_strobe) begin
      next_r.nv_data = r.cfg;
    end
    if (power_down_cmd) begin
      next_r.serial_mode = 1'b0; // [RULE9]
    end else if (serial_power_up_cmd) begin
      next_r.serial_mode = 1'b1;
    end
    // standalone operations end in power-down, serial ones stay powered
    rest_op = r.serial_mode ? OP_POWER_UP : OP_POWER_DOWN;
    unique case (r.op)
      OP_POWER_DOWN, OP_POWER_UP: begin
        if (record_start) begin
          next_r.op = OP_RECORD; // [RULE17]
        end else if (play_start) begin
          next_r.op = OP_PLAY;
        end else if (ft_on) begin
          next_r.op = OP_PASSTHRU;
        end else if (serial_power_up_cmd) begin
          next_r.op = OP_POWER_UP;
        end
      end
      OP_PASSTHRU: begin
        if (record_start) begin
          next_r.op = OP_RECORD;
        end else if (play_start) begin
          next_r.op = OP_PLAY;
        end else if (!ft_on) begin
          next_r.op = rest_op;
        end
      end
      OP_RECORD, OP_PLAY: begin
        if (op_stop) begin
          next_r.op = rest_op;
        end
      end
    endcase
    if (power_down_cmd) begin
      next_r.op = OP_POWER_DOWN; // [RULE17]
    end
    next_r.sel = u_path.sel; // [RULE12] [RULE18]
    next_r.cur_out = !next_r.cfg[`APC_DRV_BIT]; // [RULE13]
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign cfg_read_valid         = r.read_valid;
  assign cfg_read_data          = r.read_data;
  assign nv_write_strobe        = r.nv_wr;
  assign nv_write_data          = r.nv_data;
  assign serial_mode            = r.serial_mode;
  assign op_state               = r.op;
  assign analog_path_config     = r.cfg;
  assign volume_step            = r.cfg[`APC_VOL_MSB:`APC_VOL_LSB]; // [RULE5]
  assign effect_edit_disable    = r.cfg[`APC_EDIT_BIT]; // [RULE8]
  // own flop fed from the same next value, so no glue sits on the pin
  assign current_output         = r.cur_out; // [RULE13]
  assign aux_output             = r.cfg[`APC_DRV_BIT];
  assign speaker_bridge_disable = r.cfg[`APC_SPK_BIT]; // [RULE14]
  assign output_power_off       = r.cfg[`APC_PWR_BIT]; // [RULE15]
  assign message_end_stop       = r.cfg[`APC_EOM_BIT]; // [RULE16]
  assign rec_mic                = r.sel.rec_mic;
  assign rec_aux                = r.sel.rec_aux;
  assign ft_mic                 = r.sel.ft_mic;
  assign ft_aux                 = r.sel.ft_aux;
  assign play_storage           = r.sel.play_storage;
  assign play_aux               = r.sel.play_aux;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_released;
    $fell(rst);
  endsequence

  sequence s_commit_done;
    nv_write_strobe && nv_write_data == $past(analog_path_config);
  endsequence

  sequence s_idle_bus;
    !reset_func_req && !cfg_load_strobe && !r.load_pending;
  endsequence

  property p_reset_load;
    s_released |=> analog_path_config == $past(nonvolatile_config_bits);
  endproperty
  a_reset_load: assert property (p_reset_load) // [RULE1]
    else $error("register not reloaded after reset");

  property p_func_reload;
    reset_func_req |=> analog_path_config == $past(nonvolatile_config_bits);
  endproperty
  a_func_reload: assert property (p_func_reload) // [RULE1]
    else $error("reset function did not reload stored bits");

  property p_load;
    (cfg_load_strobe && !reset_func_req && !r.load_pending)
      |=> analog_path_config == $past(cfg_load_data);
  endproperty
  a_load: assert property (p_load) // [RULE3]
    else $error("serial load lost");

  property p_read;
    cfg_read_strobe |=> cfg_read_valid
      && cfg_read_data == $past(analog_path_config) ##1 !cfg_read_valid
      || $past(cfg_read_strobe);
  endproperty
  a_read: assert property (p_read) // [RULE3]
    else $error("read answer wrong");

  property p_commit;
    cfg_commit_strobe |=> s_commit_done;
  endproperty
  a_commit: assert property (p_commit) // [RULE4]
    else $error("commit did not copy register");

  property p_hold;
    s_idle_bus |=> $stable(analog_path_config);
  endproperty
  a_hold: assert property (p_hold) // [RULE18]
    else $error("register changed without load");

  property p_volume;
    (cfg_load_strobe && !reset_func_req && !r.load_pending)
      |=> volume_step == $past(cfg_load_data[`APC_VOL_MSB:`APC_VOL_LSB])
      && effect_edit_disable == $past(cfg_load_data[`APC_EDIT_BIT]);
  endproperty
  a_volume: assert property (p_volume) // [RULE5]
    else $error("volume or edit field mismatch");

  property p_no_monitor;
    (op_state == OP_RECORD && !analog_path_config[`APC_MON_BIT])
      |=> !ft_mic && !ft_aux;
  endproperty
  a_no_monitor: assert property (p_no_monitor) // [RULE6]
    else $error("input fed through while not monitoring");

  property p_rec_source;
    (op_state == OP_RECORD) |=> rec_aux == $past(ft_on)
      && rec_mic == $past(!ft_on || analog_path_config[`APC_MIX_BIT]);
  endproperty
  a_rec_source: assert property (p_rec_source) // [RULE7]
    else $error("record source wrong");

  property p_serial_ft;
    (serial_mode && analog_path_config[`APC_SFT_BIT] && !passthru_pin_n
      && op_state == OP_PLAY) |=> !play_aux;
  endproperty
  a_serial_ft: assert property (p_serial_ft) // [RULE9]
    else $error("pin still controls feed-through in serial mode");

  property p_mode;
    power_down_cmd |=> !serial_mode && op_state == OP_POWER_DOWN;
  endproperty
  a_mode: assert property (p_mode) // [RULE9]
    else $error("power-down did not leave serial mode");

  property p_play_plain;
    (op_state == OP_PLAY && !ft_on) |=> play_storage && !play_aux;
  endproperty
  a_play_plain: assert property (p_play_plain) // [RULE10]
    else $error("playback mixed without feed-through");

  property p_idle_ft;
    (op_state == OP_PASSTHRU) |=> ft_aux
      && ft_mic == $past(analog_path_config[`APC_MIX_BIT]);
  endproperty
  a_idle_ft: assert property (p_idle_ft) // [RULE11]
    else $error("idle feed-through path wrong");

  property p_drivers;
    (cfg_load_strobe && !reset_func_req && !r.load_pending)
      |=> current_output != aux_output
      && aux_output == $past(cfg_load_data[`APC_DRV_BIT])
      && speaker_bridge_disable == $past(cfg_load_data[`APC_SPK_BIT])
      && output_power_off == $past(cfg_load_data[`APC_PWR_BIT])
      && message_end_stop == $past(cfg_load_data[`APC_EOM_BIT]);
  endproperty
  a_drivers: assert property (p_drivers) // [RULE13]
    else $error("driver selection mismatch");

  property p_fsm;
    (op_state == OP_POWER_DOWN && record_start && !power_down_cmd)
      |=> op_state == OP_RECORD ##1 rec_mic || rec_aux || op_state != OP_RECORD
      || $past(op_state) != OP_RECORD;
  endproperty
  a_fsm: assert property (p_fsm) // [RULE17]
    else $error("record request not taken");

endmodule : analog_path_config_register

/* File: logic/apc_consts.svh */
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH

// register width and factory value of the non-volatile copy
`define APC_W        12
`define APC_FACTORY  12'h440

// field positions
`define APC_VOL_LSB  0
`define APC_VOL_MSB  2
`define APC_MON_BIT  3
`define APC_MIX_BIT  4
`define APC_EDIT_BIT 5
`define APC_SFT_BIT  6
`define APC_DRV_BIT  7
`define APC_SPK_BIT  8
`define APC_PWR_BIT  9
`define APC_EOM_BIT  11

`endif

/* File: logic/apc_pkg.sv */
package apc_pkg;

  typedef enum logic [2:0] {
    OP_POWER_DOWN,
    OP_POWER_UP,
    OP_PASSTHRU,
    OP_RECORD,
    OP_PLAY
  } fsm_t;

  typedef struct packed {
    logic rec_mic;
    logic rec_aux;
    logic ft_mic;
    logic ft_aux;
    logic play_storage;
    logic play_aux;
  } path_sel_t;

endpackage : apc_pkg

/* File: logic/path_sel_if.sv */
`timescale 1ns/1ps
`include "apc_consts.svh"

interface path_sel_if;
  logic [`APC_W-1:0]  cfg;
  logic               ft_on;
  apc_pkg::fsm_t      op;
  apc_pkg::path_sel_t sel;

  modport decoder (input cfg, input ft_on, input op, output sel);
  modport owner   (output cfg, output ft_on, output op, input sel);
endinterface : path_sel_if

/* File: logic/path_decode.sv */
`timescale 1ns/1ps
`include "apc_consts.svh"

module path_decode
  import apc_pkg::*;
(
  path_sel_if.decoder bus
);

  logic mix;
  logic mon;
  logic rec;

  always_comb begin
    mix = bus.cfg[`APC_MIX_BIT];
    mon = bus.cfg[`APC_MON_BIT];
    rec = (bus.op == OP_RECORD);
    // record source: mic unless feed-through is on, then aux (+mic) [RULE7]
    bus.sel.rec_mic      = rec && (!bus.ft_on || mix);
    bus.sel.rec_aux      = rec && bus.ft_on;
    // idle feed-through, plus the recorded input when monitoring [RULE11]
    // feed-through off: only the mic is monitored [RULE10] [RULE6]
    bus.sel.ft_mic       = (bus.op == OP_PASSTHRU && mix)
                         || (rec && mon && (!bus.ft_on || mix));
    bus.sel.ft_aux       = (bus.op == OP_PASSTHRU)
                         || (rec && mon && bus.ft_on);
    // playback mixes aux in only with feed-through on [RULE10] [RULE11]
    bus.sel.play_storage = (bus.op == OP_PLAY);
    bus.sel.play_aux     = (bus.op == OP_PLAY) && bus.ft_on;
  end

endmodule : path_decode

/* File: verif/nv_store_model.sv */
`timescale 1ns/1ps
`include "apc_consts.svh"

// stands in for the non-volatile cells: keeps its value across resets
module nv_store_model (
  input  wire logic              ref_clk,
  input  wire logic              nv_write_strobe,
  input  wire logic [`APC_W-1:0] nv_write_data,
  output logic      [`APC_W-1:0] nonvolatile_config_bits
);
  initial nonvolatile_config_bits = `APC_FACTORY;

  always @(posedge ref_clk) begin
    if (nv_write_strobe === 1'b1) begin
      nonvolatile_config_bits <= nv_write_data;
    end
  end
endmodule : nv_store_model

/* File: verif/test_analog_path_config_register.sv */
`timescale 1ns/1ps
`include "apc_consts.svh"

module test_analog_path_config_register import apc_pkg::*;;
  logic ref_clk, rst, reset_func_req, cfg_load_strobe, cfg_read_strobe;
  logic cfg_commit_strobe, serial_power_up_cmd, power_down_cmd;
  logic passthru_pin_n, record_start, play_start, op_stop;
  logic [`APC_W-1:0] cfg_load_data, nonvolatile_config_bits, cfg_read_data;
  logic [`APC_W-1:0] nv_write_data, analog_path_config, d;
  logic cfg_read_valid, nv_write_strobe, serial_mode, effect_edit_disable;
  logic current_output, aux_output, speaker_bridge_disable;
  logic output_power_off, message_end_stop, rec_mic, rec_aux, ft_mic;
  logic ft_aux, play_storage, play_aux;
  logic [2:0] volume_step;
  fsm_t       op_state;
  int         fail_count = 0;
  int         n_compared = 0;
  int         cycles = 0;

  analog_path_config_register uut (
    .ref_clk, .rst, .reset_func_req, .nonvolatile_config_bits,
    .cfg_load_strobe, .cfg_load_data, .cfg_read_strobe, .cfg_read_valid,
    .cfg_read_data, .cfg_commit_strobe, .nv_write_strobe, .nv_write_data,
    .serial_power_up_cmd, .power_down_cmd, .passthru_pin_n, .record_start,
    .play_start, .op_stop, .serial_mode, .op_state, .analog_path_config,
    .volume_step, .effect_edit_disable, .current_output, .aux_output,
    .speaker_bridge_disable, .output_power_off, .message_end_stop,
    .rec_mic, .rec_aux, .ft_mic, .ft_aux, .play_storage, .play_aux
  );

  nv_store_model nv (
    .ref_clk, .nv_write_strobe, .nv_write_data, .nonvolatile_config_bits
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("mismatches %0d, compared %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  // a hang counts as a mismatch, then the usual report
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done;
    end
  end

  task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  task load(input logic [11:0] v);
    cfg_load_strobe = 1'b1;
    cfg_load_data = v;
    tick;
    cfg_load_strobe = 1'b0;
  endtask : load

  task read_chk(input logic [11:0] v);
    cfg_read_strobe = 1'b1;
    tick;
    cfg_read_strobe = 1'b0;
    chk("read_valid", cfg_read_valid, 1);
    chk("read_data", cfg_read_data, v);
    tick;
    chk("read_valid_end", cfg_read_valid, 0);
  endtask : read_chk

  // pin and stored bit always disagree, so only the right source passes
  task path(input logic sm, input logic [2:0] c);
    logic ft, mix, mon;
    ft = c[2];
    mix = c[1];
    mon = c[0];
    d = 12'h000;
    d[6] = sm ? !ft : ft;
    d[4] = mix;
    d[3] = mon;
    passthru_pin_n = sm ? ft : !ft;
    load(d);
    repeat (5) tick;
    chk("idle_op", op_state,
        ft ? OP_PASSTHRU : (sm ? OP_POWER_UP : OP_POWER_DOWN));
    chk("idle_ft_aux", ft_aux, ft);
    chk("idle_ft_mic", ft_mic, ft && mix);
    record_start = 1'b1;
    play_start = 1'b1;
    tick;
    record_start = 1'b0;
    chk("rec_op", op_state, OP_RECORD);
    tick;
    play_start = 1'b0;
    chk("rec_hold", op_state, OP_RECORD);
    chk("rec_mic", rec_mic, !ft || mix);
    chk("rec_aux", rec_aux, ft);
    chk("rec_ft_mic", ft_mic, mon && (!ft || mix));
    chk("rec_ft_aux", ft_aux, mon && ft);
    op_stop = 1'b1;
    tick;
    op_stop = 1'b0;
    repeat (2) tick;
    play_start = 1'b1;
    tick;
    play_start = 1'b0;
    chk("play_op", op_state, OP_PLAY);
    tick;
    chk("play_storage", play_storage, 1);
    chk("play_aux", play_aux, ft);
    chk("play_rec_mic", rec_mic, 0);
    op_stop = 1'b1;
    tick;
    op_stop = 1'b0;
  endtask : path

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_func_req, cfg_load_strobe, cfg_read_strobe, cfg_commit_strobe} = 0;
    {serial_power_up_cmd, power_down_cmd, record_start, play_start} = 0;
    op_stop = 1'b0;
    cfg_load_data = 12'h000;
    passthru_pin_n = 1'b1;
    rst = 1'b1;
    repeat (16) tick;
    chk("cfg_in_reset", analog_path_config, 12'h440);
    rst = 1'b0;
    tick;
    tick;
    chk("cfg_por", analog_path_config, 12'h440);
    chk("op_por", op_state, OP_POWER_DOWN);
    // eight volume codes, then each bit alone
    for (int i = 0; i < 20; i++) begin
      d = (i < 8) ? 12'(i) : 12'h001 << (i - 8);
      load(d);
      chk("cfg", analog_path_config, d);
      chk("volume", volume_step, d[2:0]);
      chk("edit_dis", effect_edit_disable, d[5]);
      chk("cur_out", current_output, !d[7]);
      chk("aux_out", aux_output, d[7]);
      chk("spk_dis", speaker_bridge_disable, d[8]);
      chk("pwr_off", output_power_off, d[9]);
      chk("eom_stop", message_end_stop, d[11]);
      read_chk(d);
      chk("cfg_held", analog_path_config, d);
    end
    load(12'hb2d);
    cfg_commit_strobe = 1'b1;
    tick;
    cfg_commit_strobe = 1'b0;
    chk("nv_strobe", nv_write_strobe, 1);
    chk("nv_data", nv_write_data, 12'hb2d);
    tick;
    chk("nv_strobe_end", nv_write_strobe, 0);
    load(12'h123);
    tick;
    // a load beside the reset function must lose
    reset_func_req = 1'b1;
    cfg_load_strobe = 1'b1;
    tick;
    reset_func_req = 1'b0;
    cfg_load_strobe = 1'b0;
    chk("cfg_rfunc", analog_path_config, 12'hb2d);
    tick;
    load(12'h000);
    rst = 1'b1;
    repeat (2) tick;
    rst = 1'b0;
    tick;
    tick;
    chk("cfg_rst_nv", analog_path_config, 12'hb2d);
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        serial_power_up_cmd = 1'b1;
        tick;
        serial_power_up_cmd = 1'b0;
        chk("serial_on", serial_mode, 1);
      end
      for (int c = 0; c < 8; c++) path(s[0], 3'(c));
    end
    power_down_cmd = 1'b1;
    tick;
    power_down_cmd = 1'b0;
    chk("serial_off", serial_mode, 0);
    chk("op_pd", op_state, OP_POWER_DOWN);
    test_done;
  end
endmodule : test_analog_path_config_register
